// ### logic/ee_slave.sv
// Two-wire serial memory slave: protocol engine, page buffer and array
//
// Behaviour
// [R1] SDA falling while SCL high is a start; recognised at any time. The code ignores it while busy_r is set during programming.
// [R2] SDA rising while SCL high is a stop; after reads it returns to standby.
// [R3] SDA changes only while SCL low; changes in SCL high mean start or stop.
// [R4] Words are 8 bits; the device pulls SDA low on the ninth clock to acknowledge.
// [R5] Standby at power-up and after stop once internal operations finish.
// [R6] Master recovers the bus by up to 9 SCL clocks then a start.
// [R7] Each operation starts with a device address word; top five bits fixed.
// [R8] Two address bits must match the two strap inputs.
// [R9] Eighth address bit: one means read, zero means write.
// [R10] Match gets an acknowledge; mismatch stays off the bus and returns to standby.
// [R11] Write-lock high blocks every write to the array.
// [R12] Byte write: address, two word-address bytes, one data byte, stop starts programming.
// [R13] During programming all inputs ignored, no response, for 10 ms or 20 ms.
// [R14] Page write: up to 63 more data bytes, each acknowledged, ended by stop.
// [R15] Writes increment only the low 6 address bits, wrapping inside the page.
// [R16] Polling during programming is not acknowledged until programming has finished.
// [R17] Address counter holds last accessed address plus one between operations.
// [R18] Reads advance the counter over the whole array and wrap to zero.
// [R19] Current read: acknowledge address, send byte at counter, master nacks and stops.
// [R20] Random read uses a dummy write, repeated start, then a read address.
// [R21] Sequential read: each master acknowledge sends the next byte; nack then stop ends.
// [R22] Pages of 64 bytes; 14-bit or 15-bit word address by variant.
// [R23] Sample SDA on SCL rising edges, launch SDA on SCL falling edges.
// [R24] Smaller variant ignores the top received word-address bit.
// [R25] SDA only driven low as open drain, released during programming.
`timescale 1ns/10ps

module ee_slave
  import ee_pkg::*;
#(
  parameter bit large_variant_p = 1'b1,
  parameter bit low_volt_p = 1'b0,
  parameter int prog_cycles_p = PROG_CYCLES,
  parameter int prog_lv_cycles_p = PROG_LV_CYCLES
) (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Two-wire link; SCL also clocks the link-side flops
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Straps and write lock
  input wire logic strap_select_hi_in,
  input wire logic strap_select_lo_in,
  input wire logic write_lock_in,
  // Status
  output logic standby_out,
  output logic busy_out
);

  // Link domain: bit capture on rising SCL, drive on falling SCL
  logic rise_tgl_r;
  logic bit_cap_r;
  logic drv_low_r;

  // System domain synchronisers
  ee_pins_t pins_w;
  ee_pins_t pin_s1_r;
  ee_pins_t pin_s2_r;
  ee_pins_t pin_s3_r;
  logic rt_s1_r;
  logic rt_s2_r;
  logic rt_s3_r;

  // Protocol state
  ee_state_t state_r;
  ee_state_t state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shreg_r;
  logic [7:0] shreg_nxt;
  logic [14:0] addr_r;
  logic [14:0] addr_nxt;
  logic [6:0] hi_r;
  logic [6:0] hi_nxt;
  logic rd_r;
  logic rd_nxt;
  logic drive_r;
  logic drive_nxt;
  logic has_data_r;
  logic has_data_nxt;
  logic [63:0] vld_r;
  logic [63:0] vld_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [22:0] busy_cnt_r;
  logic [6:0] commit_idx_r;

  // Storage
  logic [7:0] mem_r [MEM_BYTES];
  logic [7:0] buf_r [PAGE_BYTES];

  // Link side: capture SDA and flag every rising SCL edge by a toggle
  always_ff @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      rise_tgl_r <= 1'b0;
      bit_cap_r <= 1'b1;
    end else begin
      rise_tgl_r <= ~rise_tgl_r;
      bit_cap_r <= sda_in; // see [R23]
    end
  end

  // Link side: drive level prepared well ahead, taken on falling SCL
  // drive_r settles within a few system cycles of the rising edge, far
  // inside the SCL high time, so it is stable when this flop samples it
  always_ff @(negedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      drv_low_r <= 1'b0;
    end else begin
      drv_low_r <= drive_r; // see [R23] see [R3]
    end
  end

  // Open drain only: data is always low, the enable does the work
  assign sda_out = 1'b0; // see [R25]
  assign sda_oe_n_out = ~(drv_low_r & ~busy_r); // see [R25] see [R13]

  // Pins into the system domain
  assign pins_w = '{scl: scl_in, sda: sda_in, strap_hi: strap_select_hi_in,
                    strap_lo: strap_select_lo_in, wlock: write_lock_in};

  // Two-stage synchronisers; the third stage feeds the edge detectors
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1_r <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
      pin_s2_r <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
      pin_s3_r <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
      rt_s1_r <= 1'b0;
      rt_s2_r <= 1'b0;
      rt_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= pins_w;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      rt_s1_r <= rise_tgl_r;
      rt_s2_r <= rt_s1_r;
      rt_s3_r <= rt_s2_r;
    end
  end

  // Bus events; SCL must be high on both sampled stages
  logic scl_high_w;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic bit_in_w;
  assign scl_high_w = pin_s2_r.scl & pin_s3_r.scl;
  assign start_w = scl_high_w & pin_s3_r.sda & ~pin_s2_r.sda; // see [R1]
  assign stop_w = scl_high_w & ~pin_s3_r.sda & pin_s2_r.sda; // see [R2]
  assign rise_w = rt_s2_r ^ rt_s3_r;
  // Captured bit is stable until the next rising SCL, long after the toggle
  assign bit_in_w = bit_cap_r;

  // Word decode
  logic [7:0] rx_byte_w;
  logic dev_match_w;
  logic [14:0] addr_mask_w;
  logic [14:0] addr_inc_w;
  logic [14:0] page_inc_w;
  logic [14:0] addr_load_w;
  logic [7:0] mem_rd_w;
  logic byte_done_w;
  logic ninth_w;
  logic active_w;
  assign rx_byte_w = {shreg_r[6:0], bit_in_w};
  assign dev_match_w = (rx_byte_w[7:3] == DEV_CODE) // see [R7]
    & (rx_byte_w[2] == pin_s2_r.strap_hi) // see [R8]
    & (rx_byte_w[1] == pin_s2_r.strap_lo); // see [R8]
  assign addr_mask_w = large_variant_p ? ADDR_MASK_LARGE : ADDR_MASK_SMALL; // see [R22]
  assign addr_inc_w = (addr_r + ADDR_ONE) & addr_mask_w; // see [R18]
  assign page_inc_w = {addr_r[14:6], addr_r[5:0] + PAGE_ONE}; // see [R15]
  assign addr_load_w = {hi_r, rx_byte_w} & addr_mask_w; // see [R24]
  assign mem_rd_w = mem_r[addr_r & addr_mask_w];
  assign byte_done_w = rise_w & (bit_cnt_r == BIT_LAST_DATA);
  assign ninth_w = rise_w & (bit_cnt_r == BIT_ACK);
  assign active_w = (state_r != ST_IDLE) & (state_r != ST_IGNORE);

  // Protocol engine next state
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shreg_nxt = shreg_r;
    addr_nxt = addr_r;
    hi_nxt = hi_r;
    rd_nxt = rd_r;
    drive_nxt = drive_r;
    has_data_nxt = has_data_r;
    vld_nxt = vld_r;
    busy_nxt = busy_r;
    if (busy_r) begin
      // Nothing on the bus is looked at while programming
      state_nxt = ST_IDLE; // see [R13] see [R16]
      drive_nxt = 1'b0;
      if (busy_cnt_r == BUSY_CNT_W'(low_volt_p ? prog_lv_cycles_p : prog_cycles_p)) begin
        busy_nxt = 1'b0; // see [R5]
        vld_nxt = '0;
      end
    end else if (start_w) begin
      // A repeated start drops any unfinished write data
      state_nxt = ST_DEV; // see [R1]
      bit_cnt_nxt = BIT_ZERO;
      drive_nxt = 1'b0;
      has_data_nxt = 1'b0;
      vld_nxt = '0;
    end else if (stop_w) begin
      state_nxt = ST_IDLE; // see [R2] see [R5]
      drive_nxt = 1'b0;
      if ((state_r == ST_WDATA) && has_data_r && !pin_s2_r.wlock) begin
        busy_nxt = 1'b1; // see [R12] see [R11]
      end else begin
        vld_nxt = '0;
      end
      has_data_nxt = 1'b0;
    end else if (rise_w && active_w) begin
      if (!ninth_w) begin
        // Shift both ways: the next transmit bit sits in rx_byte_w[7]
        shreg_nxt = rx_byte_w;
        bit_cnt_nxt = bit_cnt_r + BIT_ONE;
        drive_nxt = (state_r == ST_RDATA) ? ~rx_byte_w[7] : 1'b0;
      end
      if (byte_done_w) begin
        unique case (state_r)
          ST_DEV: begin
            if (dev_match_w) begin
              drive_nxt = 1'b1; // see [R10] see [R4]
              rd_nxt = rx_byte_w[0]; // see [R9]
            end else begin
              // Straight back to standby; active_w keeps later clocks out
              state_nxt = ST_IDLE; // see [R10]
              drive_nxt = 1'b0;
            end
          end
          ST_ADDR_HI: begin
            hi_nxt = rx_byte_w[6:0];
            drive_nxt = 1'b1; // see [R4]
          end
          ST_ADDR_LO: begin
            addr_nxt = addr_load_w; // see [R20]
            drive_nxt = 1'b1; // see [R4]
          end
          ST_WDATA: begin
            vld_nxt[addr_r[5:0]] = 1'b1;
            addr_nxt = page_inc_w; // see [R15] see [R17]
            has_data_nxt = 1'b1;
            drive_nxt = 1'b1; // see [R4] see [R14]
          end
          ST_RDATA: begin
            drive_nxt = 1'b0; // Release for the master's answer
          end
          default: begin
            drive_nxt = 1'b0;
          end
        endcase
      end
      if (ninth_w) begin
        bit_cnt_nxt = BIT_ZERO;
        drive_nxt = 1'b0;
        unique case (state_r)
          ST_DEV: begin
            if (rd_r) begin
              state_nxt = ST_RDATA; // see [R19]
              shreg_nxt = mem_rd_w;
              drive_nxt = ~mem_rd_w[7];
              addr_nxt = addr_inc_w; // see [R17] see [R18]
            end else begin
              state_nxt = ST_ADDR_HI; // see [R12]
            end
          end
          ST_ADDR_HI: begin
            state_nxt = ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            state_nxt = ST_WDATA;
          end
          ST_WDATA: begin
            state_nxt = ST_WDATA; // see [R14]
          end
          ST_RDATA: begin
            if (!bit_in_w) begin
              shreg_nxt = mem_rd_w; // see [R21]
              drive_nxt = ~mem_rd_w[7];
              addr_nxt = addr_inc_w; // see [R18]
            end else begin
              state_nxt = ST_IGNORE; // see [R21] see [R19]
            end
          end
          default: begin
            state_nxt = ST_IGNORE;
          end
        endcase
      end
    end
  end

  // Protocol registers; the address counter survives between operations
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE; // see [R5]
      bit_cnt_r <= BIT_ZERO;
      shreg_r <= 8'h00;
      addr_r <= ADDR_RESET;
      hi_r <= 7'h00;
      rd_r <= 1'b0;
      drive_r <= 1'b0;
      has_data_r <= 1'b0;
      vld_r <= '0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shreg_r <= shreg_nxt;
      addr_r <= addr_nxt; // see [R17]
      hi_r <= hi_nxt;
      rd_r <= rd_nxt;
      drive_r <= drive_nxt;
      has_data_r <= has_data_nxt;
      vld_r <= vld_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Programming timer and commit index, both run only while busy
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_cnt_r <= '0;
      commit_idx_r <= '0;
    end else if (busy_r) begin
      busy_cnt_r <= busy_cnt_r + BUSY_CNT_ONE; // see [R13]
      if (!commit_idx_r[6]) begin
        commit_idx_r <= commit_idx_r + COMMIT_ONE;
      end
    end else begin
      busy_cnt_r <= '0;
      commit_idx_r <= '0;
    end
  end

  // Page buffer write and array commit
  logic buf_wr_w;
  logic commit_w;
  logic [14:0] commit_addr_w;
  assign buf_wr_w = byte_done_w & (state_r == ST_WDATA) & ~busy_r & ~start_w & ~stop_w;
  assign commit_w = busy_r & ~commit_idx_r[6] & vld_r[commit_idx_r[5:0]];
  assign commit_addr_w = {addr_r[14:6], commit_idx_r[5:0]};

  // Buffered bytes reach the array only after the stop, one per cycle
  always_ff @(posedge sys_clk_in) begin
    if (buf_wr_w) begin
      buf_r[addr_r[5:0]] <= rx_byte_w; // see [R15]
    end
    if (commit_w) begin
      mem_r[commit_addr_w] <= buf_r[commit_idx_r[5:0]]; // see [R12] see [R11]
    end
  end

  // Status
  assign standby_out = (state_r == ST_IDLE) & ~busy_r; // see [R5]
  assign busy_out = busy_r;

endmodule

// ### logic/ee_pkg.sv
// Shared constants and types for the two-wire serial memory slave
package ee_pkg;

  // Word and array geometry
  localparam int WORD_W = 8;
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int MEM_BYTES = 32768;
  localparam int ROW_W = ADDR_W - PAGE_W;

  // Address masks for the larger and the smaller array
  localparam logic [14:0] ADDR_MASK_LARGE = 15'h7fff;
  localparam logic [14:0] ADDR_MASK_SMALL = 15'h3fff;
  localparam logic [14:0] ADDR_ONE = 15'h0001;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [5:0] PAGE_ONE = 6'h01;

  // Fixed upper five bits of the device address word
  localparam logic [4:0] DEV_CODE = 5'h14;

  // Bit counter: bits 0..7 are data, count 8 marks the ninth clock
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Internal programming time, in ms, and its count at the system clock
  localparam int SYS_CLK_KHZ = 200000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_TIME_LV_MS = 20;
  localparam int PROG_CYCLES = PROG_TIME_MS * SYS_CLK_KHZ;
  localparam int PROG_LV_CYCLES = PROG_TIME_LV_MS * SYS_CLK_KHZ;
  localparam int BUSY_CNT_W = 23;
  localparam logic [22:0] BUSY_CNT_ONE = 23'h00_0001;
  localparam logic [6:0] COMMIT_ONE = 7'h01;

  // Pins that are brought into the system clock domain together
  typedef struct packed {
    logic scl;
    logic sda;
    logic strap_hi;
    logic strap_lo;
    logic wlock;
  } ee_pins_t;

  // Protocol engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } ee_state_t;

endpackage

// ### dv/ee_slave_properties.sv
// Concurrent checks on the ports of the two-wire memory slave
`timescale 1ns/10ps

module ee_slave_properties #(
  parameter int prog_cycles_p = 200
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Link and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic standby_out,
  input wire logic busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [22:0] busy_cnt_r;

  // Length of the programming time; the commit may sit inside it
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) busy_cnt_r <= '0;
    else if (busy_out) busy_cnt_r <= busy_cnt_r + 23'h00_0001;
    else busy_cnt_r <= '0;
  end

  // Link and status relations
  sda_low_only_a: assert property (sda_out == 1'b0) else $error("SDA driven high");
  quiet_busy_a: assert property (busy_out |-> sda_oe_n_out) else $error("Drive while busy");
  busy_not_idle_a: assert property (busy_out |-> !standby_out) else $error("Standby while busy");
  idle_quiet_a: assert property (standby_out |-> sda_oe_n_out) else $error("Drive while idle");
  drive_scl_low_a: assert property ($changed(sda_oe_n_out) |-> !scl_in) else $error("Drive moved");
  busy_at_stop_a: assert property ($rose(busy_out) |-> scl_in && sda_in) else $error("Busy without stop");
  prog_time_a: assert property ($fell(busy_out) |-> busy_cnt_r <= prog_cycles_p + 2 &&
    busy_cnt_r >= prog_cycles_p - 66) else $error("Programming time off");
  start_wakes_a: assert property (scl_in && $past(scl_in) && $fell(sda_in) && !busy_out
    |-> ##[1:6] !standby_out) else $error("Start not seen");
  stop_rests_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) && !busy_out
    |-> ##[1:6] (standby_out || busy_out)) else $error("Stop not seen");
  ready_after_a: assert property ($fell(busy_out) |-> ##[0:4] standby_out) else $error("No standby after busy");
endmodule

// ### dv/ee_master_model.sv
// Behavioural two-wire bus master driving the slave's link
`timescale 1ns/10ps

module ee_master_model #(
  parameter int half_ticks_p = 24
) (
  // Resolved wire level
  input wire logic sda_wire_in,
  // Master drives; SCL stands high between frames
  output logic scl_out,
  output logic sda_out
);
  localparam int QT = half_ticks_p / 2;
  logic tick;

  // Own 6 ns timebase, unrelated to the system clock
  initial begin
    tick = 1'b0;
    scl_out = 1'b1;
    sda_out = 1'b1;
    #1.7;
    forever #3 tick = ~tick;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask

  // SDA moves mid-low so no edge meets SCL high by accident
  task automatic start();
    wt(QT);
    sda_out <= 1'b1;
    wt(QT);
    scl_out <= 1'b1;
    wt(half_ticks_p);
    sda_out <= 1'b0;
    wt(half_ticks_p);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    wt(QT);
    sda_out <= 1'b0;
    wt(QT);
    scl_out <= 1'b1;
    wt(half_ticks_p);
    sda_out <= 1'b1;
    wt(half_ticks_p);
  endtask

  // One clock: data set in SCL low, wire sampled late in SCL high
  task automatic bit_io(input logic b, output logic r);
    wt(QT);
    sda_out <= b;
    wt(QT);
    scl_out <= 1'b1;
    wt(half_ticks_p);
    r = sda_wire_in;
    scl_out <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Last byte is not acknowledged, others are
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // Bus recovery: nine clocks with SDA released, then start and stop
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) bit_io(1'b1, r);
    start();
    stop();
  endtask
endmodule

// ### dv/tb_ee_slave.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/10ps

`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end

module tb_ee_slave;
  import ee_pkg::*;
  localparam int PROG_P = 2000;
  logic sys_clk_in, rst_in, strap_hi_r, strap_lo_r, wlock_r, standby, busy, sda_d, oe_n;
  wire logic scl, m_sda, sda_wire;
  logic [6:0] dev_hi = {DEV_CODE, 2'b10};
  logic [23:0] q;
  logic ak;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  // Pull-up wire: low when either party pulls it
  assign sda_wire = m_sda & (oe_n | sda_d);

  ee_slave #(.large_variant_p(1'b1), .low_volt_p(1'b0), .prog_cycles_p(PROG_P),
    .prog_lv_cycles_p(2 * PROG_P)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_d), .sda_oe_n_out(oe_n), .strap_select_hi_in(strap_hi_r),
    .strap_select_lo_in(strap_lo_r), .write_lock_in(wlock_r), .standby_out(standby), .busy_out(busy));
  ee_master_model m (.sda_wire_in(sda_wire), .scl_out(scl), .sda_out(m_sda));

  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Start, write-direction device word, two word-address bytes
  task automatic addr_phase(input logic [14:0] a, output logic ok);
    logic a0, a1, a2;
    m.start();
    m.put_byte({dev_hi, 1'b0}, a0);
    m.put_byte({1'b1, a[14:8]}, a1);
    m.put_byte(a[7:0], a2);
    ok = a0 & a1 & a2;
  endtask

  task automatic wr(input logic [14:0] a, input logic [23:0] d, input int n);
    logic ok, ak1;
    addr_phase(a, ok);
    for (int i = 0; i < n; i++) begin
      m.put_byte(d[23 - 8 * i -: 8], ak1);
      ok &= ak1;
    end
    m.stop();
    `CHECK("write acks", 1'b1, ok)
  endtask

  // Poll until programming ends
  task automatic wait_ready();
    logic ak1;
    for (int i = 0; i < 40; i++) begin
      m.start();
      m.put_byte({dev_hi, 1'b0}, ak1);
      m.stop();
      if (ak1) break;
    end
    `CHECK("poll ack", 1'b1, ak1)
  endtask

  // Random read: dummy write, repeated start, n bytes in sequence
  task automatic rd(input logic [14:0] a, input int n, output logic [23:0] d);
    logic ok, ak1;
    logic [7:0] b;
    d = '0;
    addr_phase(a, ok);
    m.start();
    m.put_byte({dev_hi, 1'b1}, ak1);
    for (int i = 0; i < n; i++) begin
      m.get_byte(i == n - 1, b);
      d[23 - 8 * i -: 8] = b;
    end
    m.stop();
    `CHECK("read acks", 1'b1, ok & ak1)
  endtask

  task automatic t_byte_write();
    wr(15'h0123, 24'hA5_0000, 1);
    repeat (10) @(posedge sys_clk_in);
    `CHECK("busy", 1'b1, busy)
    m.start();
    m.put_byte({dev_hi, 1'b0}, ak);
    m.stop();
    `CHECK("busy poll", 1'b0, ak)
    wait_ready();
    `CHECK("standby", 1'b1, standby)
    rd(15'h0123, 1, q);
    `CHECK("byte read", 24'hA5_0000, q)
  endtask

  task automatic t_page_wrap();
    logic [7:0] b;
    wr(15'h007E, 24'h11_2233, 3);
    wait_ready();
    rd(15'h007E, 1, q);
    `CHECK("page byte0", 24'h11_0000, q)
    m.start();
    m.put_byte({dev_hi, 1'b1}, ak);
    m.get_byte(1'b1, b);
    m.stop();
    `CHECK("current read", 8'h22, b)
    rd(15'h0040, 1, q);
    `CHECK("page wrap", 24'h33_0000, q)
  endtask

  task automatic t_array_wrap();
    wr(15'h7FFF, 24'h77_0000, 1);
    wait_ready();
    wr(15'h0000, 24'h66_0000, 1);
    wait_ready();
    rd(15'h7FFF, 2, q);
    `CHECK("array wrap", 24'h7766_00, q)
  endtask

  task automatic t_lock_strap();
    @(posedge sys_clk_in);
    wlock_r <= 1'b1;
    wr(15'h0123, 24'h5A_0000, 1);
    repeat (20) @(posedge sys_clk_in);
    `CHECK("locked busy", 1'b0, busy)
    wlock_r <= 1'b0;
    m.start();
    m.put_byte({DEV_CODE, 2'b01, 1'b0}, ak);
    repeat (4) @(posedge sys_clk_in);
    `CHECK("mismatch standby", 1'b1, standby)
    m.stop();
    `CHECK("mismatch ack", 1'b0, ak)
    @(posedge sys_clk_in);
    strap_hi_r <= 1'b0;
    strap_lo_r <= 1'b1;
    dev_hi = {DEV_CODE, 2'b01};
    repeat (10) @(posedge sys_clk_in);
    rd(15'h0123, 1, q);
    `CHECK("locked data", 24'hA5_0000, q)
  endtask

  // System clock, 200 MHz
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // Hang guard well above the expected run
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    rst_in = 1'b1;
    strap_hi_r = 1'b1;
    strap_lo_r = 1'b0;
    wlock_r = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    `CHECK("reset idle", 3'b101, {standby, busy, oe_n})
    m.recover();
    t_byte_write();
    t_page_wrap();
    t_array_wrap();
    t_lock_strap();
    summarize();
  end
endmodule

bind ee_slave ee_slave_properties #(.prog_cycles_p(prog_cycles_p)) chk (.sys_clk_in(sys_clk_in),
  .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .standby_out(standby_out), .busy_out(busy_out));
